// ---- dps_pkg.sv ----
// shared constants and types for the dual pilot ignition sequencer
package dps_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int SEC_NS        = 1_000_000_000;
	localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 26;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int TEMP_W = 12;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int TIME_W = 8;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CFG0     = 4'h0;
	localparam logic [3:0] REG_CFG1     = 4'h1;
	localparam logic [3:0] REG_THR0     = 4'h2;
	localparam logic [3:0] REG_THR1     = 4'h3;
	localparam logic [3:0] REG_CMD      = 4'h4;
	localparam logic [3:0] REG_KEY      = 4'h5;
	localparam logic [3:0] REG_STATUS   = 4'h6;
	localparam logic [3:0] REG_DATETIME = 4'h7;
	localparam logic [3:0] REG_SITE     = 4'h8;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG_EN_BIT   = 0;
	localparam int CFG_SRC_BIT  = 1;
	localparam int CFG_IGN_LSB  = 8;
	localparam int CFG_PRV_LSB  = 16;
	localparam int THR_ON_LSB   = 0;
	localparam int THR_OFF_LSB  = 16;
	localparam int CMD_INST_BIT = 4;
	localparam int KEY_OK       = 0;
	localparam int KEY_YES      = 1;
	localparam int KEY_NO       = 2;
	localparam int STS_ST1_LSB  = 3;
	localparam int STS_GLOB     = 6;
	localparam int STS_FLAME0   = 7;
	localparam int STS_FLAME1   = 8;
	localparam int STS_DLG_LSB  = 9;
	localparam int STS_REFUSED  = 11;

	// ----------------------------------------------------------------
	// factory defaults
	// ----------------------------------------------------------------
	localparam logic [TIME_W-1:0] DEF_IGN_TIME = 8'h0A;
	localparam logic [TIME_W-1:0] DEF_PRV_TIME = 8'h32;
	localparam logic [TEMP_W-1:0] DEF_ON_TEMP  = 12'h12C;
	localparam logic [TEMP_W-1:0] DEF_OFF_TEMP = 12'h0C8;
	localparam logic              SRC_SPARK    = 1'h0;
	localparam logic [1:0]        DEF_ENABLE   = 2'h1;

	// ----------------------------------------------------------------
	// commands
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_START    = 3'h1;
	localparam logic [2:0] CMD_CLR_INST = 3'h2;
	localparam logic [2:0] CMD_CLR_GLOB = 3'h3;
	localparam logic [2:0] CMD_ERASE    = 3'h4;
	localparam logic [2:0] CMD_FACTORY  = 3'h5;

	typedef enum logic [2:0] {ST_HALTED, ST_IGNITE, ST_PROVE, ST_LIT, ST_ALARM} dps_inst_t;
	typedef enum logic [1:0] {DLG_IDLE, DLG_OK, DLG_INFO, DLG_CHOOSE} dps_dlg_t;

endpackage : dps_pkg

// ---- dps_flame_det.sv ----
// flame decision with hysteresis between off and on thresholds
module dps_flame_det
	import dps_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic [TEMP_W-1:0] temp,
	input  wire logic [TEMP_W-1:0] on_thr,
	input  wire logic [TEMP_W-1:0] off_thr,
	output logic                   flame_q
);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			flame_q <= 1'b0;
		else if (temp >= on_thr)
			flame_q <= 1'b1;
		else if (temp <= off_thr)
			flame_q <= 1'b0;
		// in between: keep last decision
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	flame_hold_a: assert property (
		(temp > off_thr && temp < on_thr) |=> flame_q == $past(flame_q))
		else $error("flame decision moved inside hysteresis band");

	flame_on_a: assert property (
		(temp >= on_thr) |=> flame_q)
		else $error("flame not detected at or above on threshold");

endmodule : dps_flame_det

// ---- dps_sequencer.sv ----
// dual pilot ignition sequencer: instance states, alarms, dialogs, settings
// Functional notes
// - keep igniting between proving until flame
// - start accepted only when halted, then OK
// - start affects only the selected instance
// - stop button halts both instances
// - alarm instance ignores stop until cleared
// - clearing refused while cause still present
// - alarms are instance or global scope
// - instance alarm: clear, yes, OK, halt that
// - global alarm: OK, yes, OK halts both, not one in alarm
// - factory: igniter enables, times, spark source
// - factory: on 300, off 200 both pilots
// - log erase only after yes then OK
// - export named date-time in site folder
// - flame at/above on, none at/below off
module dps_sequencer
	import dps_pkg::*;
#(
	parameter int TICK_CYCLES = SEC_CYCLES
)
(
	input  wire logic                        ref_clk,
	input  wire logic                        reset,
	input  wire logic [dps_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [dps_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [dps_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                        stop_btn,
	input  wire logic [dps_pkg::TEMP_W-1:0]  tc_temp0,
	input  wire logic [dps_pkg::TEMP_W-1:0]  tc_temp1,
	input  wire logic [1:0]                  inst_fault,
	input  wire logic                        glob_fault,
	input  wire logic                        export_req,
	output logic      [1:0]                  ign_drive,
	output logic      [1:0]                  ign_source,
	output logic                             global_alarm,
	output logic                             log_erase,
	output logic                             export_valid,
	output logic      [dps_pkg::DATA_W-1:0]  export_folder,
	output logic      [dps_pkg::DATA_W-1:0]  export_file
);
	import dps_pkg::*;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] cfg_q [2];
	logic [DATA_W-1:0] thr_q [2];
	logic [DATA_W-1:0] datetime_q;
	logic [DATA_W-1:0] site_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] folder_q;
	logic [DATA_W-1:0] file_q;
	dps_inst_t         st_q [2];
	logic [TIME_W-1:0] tmr_q [2];
	logic [1:0]        flame;
	logic [TEMP_W-1:0] temp [2];
	dps_dlg_t          dlg_q;
	logic [2:0]        dlg_cmd_q;
	logic              dlg_inst_q;
	logic              yes_sel_q;
	logic              refused_q;
	logic              glob_q;
	logic              erase_q;
	logic              valid_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic              sec_tick;
	logic              cmd_wr;
	logic              key_ok;
	logic              key_yes;
	logic              key_no;
	logic              commit;
	logic              start_go;
	logic              clr_inst_go;
	logic              clr_glob_go;
	logic              erase_go;
	logic              factory_go;
	logic [2:0]        wr_cmd;
	logic              wr_inst;

	assign temp[0] = tc_temp0;
	assign temp[1] = tc_temp1;

	// ----------------------------------------------------------------
	// one second enable
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset || tick_cnt_q == TICK_W'(TICK_CYCLES - 1))
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
	end

	assign sec_tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

	// ----------------------------------------------------------------
	// operator keys and commands
	// ----------------------------------------------------------------
	assign cmd_wr  = reg_wr && reg_addr == REG_CMD;
	assign wr_cmd  = reg_wdata[2:0];
	assign wr_inst = reg_wdata[CMD_INST_BIT];
	assign key_ok  = reg_wr && reg_addr == REG_KEY && reg_wdata[KEY_OK];
	assign key_yes = reg_wr && reg_addr == REG_KEY && reg_wdata[KEY_YES];
	assign key_no  = reg_wr && reg_addr == REG_KEY && reg_wdata[KEY_NO];

	assign commit      = dlg_q == DLG_CHOOSE && key_ok && yes_sel_q;
	assign start_go    = dlg_q == DLG_OK && key_ok;
	assign clr_inst_go = commit && dlg_cmd_q == CMD_CLR_INST && !inst_fault[dlg_inst_q];
	assign clr_glob_go = commit && dlg_cmd_q == CMD_CLR_GLOB && !glob_fault;
	assign erase_go    = commit && dlg_cmd_q == CMD_ERASE;
	assign factory_go  = cmd_wr && dlg_q == DLG_IDLE && wr_cmd == CMD_FACTORY;

	// dialog: one command at a time; a command written before the last closes is ignored
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			dlg_q      <= DLG_IDLE;
			dlg_cmd_q  <= 3'h0;
			dlg_inst_q <= 1'b0;
			yes_sel_q  <= 1'b0;
			refused_q  <= 1'b0;
		end
		else
		begin
			case (dlg_q)
				DLG_IDLE:
				begin
					if (cmd_wr)
					begin
						dlg_cmd_q  <= wr_cmd;
						dlg_inst_q <= wr_inst;
						yes_sel_q  <= 1'b0;
						refused_q  <= 1'b0;
						case (wr_cmd)
							CMD_START:
								if (st_q[wr_inst] == ST_HALTED && cfg_q[wr_inst][CFG_EN_BIT]
									&& !glob_q)
									dlg_q <= DLG_OK;
								else
									refused_q <= 1'b1;
							CMD_CLR_INST:
								if (st_q[wr_inst] == ST_ALARM)
									dlg_q <= DLG_CHOOSE;
								else
									refused_q <= 1'b1;
							CMD_CLR_GLOB:
								if (glob_q)
									dlg_q <= DLG_INFO;
								else
									refused_q <= 1'b1;
							CMD_ERASE:
								dlg_q <= DLG_CHOOSE;
							CMD_FACTORY:
								dlg_q <= DLG_IDLE;
							default:
								refused_q <= 1'b1;
						endcase
					end
				end
				DLG_OK:
					if (key_ok)
						dlg_q <= DLG_IDLE;
				DLG_INFO:
					if (key_ok)
						dlg_q <= DLG_CHOOSE;
				DLG_CHOOSE:
				begin
					if (key_yes)
						yes_sel_q <= 1'b1;
					else if (key_no)
						yes_sel_q <= 1'b0;
					if (key_ok)
					begin
						dlg_q <= DLG_IDLE;
						if (commit && ((dlg_cmd_q == CMD_CLR_INST && inst_fault[dlg_inst_q])
							|| (dlg_cmd_q == CMD_CLR_GLOB && glob_fault)))
							refused_q <= 1'b1;
					end
				end
				default:
					dlg_q <= DLG_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// global alarm
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			glob_q <= 1'b0;
		else if (glob_fault)
			glob_q <= 1'b1;
		else if (clr_glob_go)
			glob_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// per-instance sequencing
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_inst
			dps_flame_det u_flame (
				.ref_clk (ref_clk),
				.reset   (reset),
				.temp    (temp[i]),
				.on_thr  (thr_q[i][THR_ON_LSB +: TEMP_W]),
				.off_thr (thr_q[i][THR_OFF_LSB +: TEMP_W]),
				.flame_q (flame[i])
			);

			// a fault always wins, even against a clear in the same cycle
			always_ff @(posedge ref_clk)
			begin
				if (reset)
				begin
					st_q[i]  <= ST_HALTED;
					tmr_q[i] <= '0;
				end
				else if (inst_fault[i] && st_q[i] != ST_ALARM)
					st_q[i] <= ST_ALARM;
				else
				begin
					case (st_q[i])
						ST_ALARM:
							if (clr_inst_go && dlg_inst_q == 1'(i))
								st_q[i] <= ST_HALTED;
						ST_HALTED:
							if (start_go && dlg_inst_q == 1'(i) && !stop_btn)
							begin
								st_q[i]  <= ST_IGNITE;
								tmr_q[i] <= cfg_q[i][CFG_IGN_LSB +: TIME_W];
							end
						default:
						begin
							if (stop_btn || clr_glob_go)
								st_q[i] <= ST_HALTED;
							else if (glob_q)
								st_q[i] <= st_q[i];
							else if (st_q[i] == ST_LIT)
							begin
								if (!flame[i])
								begin
									st_q[i]  <= ST_IGNITE;
									tmr_q[i] <= cfg_q[i][CFG_IGN_LSB +: TIME_W];
								end
							end
							else if (flame[i])
								st_q[i] <= ST_LIT;
							else if (sec_tick)
							begin
								if (tmr_q[i] > TIME_W'(1))
									tmr_q[i] <= tmr_q[i] - TIME_W'(1);
								else if (st_q[i] == ST_IGNITE)
								begin
									st_q[i]  <= ST_PROVE;
									tmr_q[i] <= cfg_q[i][CFG_PRV_LSB +: TIME_W];
								end
								else
								begin
									st_q[i]  <= ST_IGNITE;
									tmr_q[i] <= cfg_q[i][CFG_IGN_LSB +: TIME_W];
								end
							end
						end
					endcase
				end
			end

			// settings: factory load beats a same-cycle software write
			always_ff @(posedge ref_clk)
			begin
				if (reset || factory_go)
				begin
					cfg_q[i] <= '0;
					cfg_q[i][CFG_EN_BIT] <= DEF_ENABLE[i];
					cfg_q[i][CFG_SRC_BIT] <= SRC_SPARK;
					cfg_q[i][CFG_IGN_LSB +: TIME_W] <= DEF_IGN_TIME;
					cfg_q[i][CFG_PRV_LSB +: TIME_W] <= DEF_PRV_TIME;
					thr_q[i] <= '0;
					thr_q[i][THR_ON_LSB +: TEMP_W] <= DEF_ON_TEMP;
					thr_q[i][THR_OFF_LSB +: TEMP_W] <= DEF_OFF_TEMP;
				end
				else if (reg_wr && reg_addr == REG_CFG0 + 4'(i))
					cfg_q[i] <= reg_wdata;
				else if (reg_wr && reg_addr == REG_THR0 + 4'(i))
					thr_q[i] <= reg_wdata;
			end

			assign ign_drive[i]  = st_q[i] == ST_IGNITE && !glob_q;
			assign ign_source[i] = cfg_q[i][CFG_SRC_BIT];

			stop_halt_a: assert property (@(posedge ref_clk) disable iff (reset)
				(stop_btn && st_q[i] != ST_ALARM && !inst_fault[i]) |=> st_q[i] == ST_HALTED)
				else $error("stop did not halt instance");

			alarm_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
				(st_q[i] == ST_ALARM && !(clr_inst_go && dlg_inst_q == 1'(i)))
				|=> st_q[i] == ST_ALARM)
				else $error("alarm left without its clear");

			start_only_a: assert property (@(posedge ref_clk) disable iff (reset)
				(st_q[i] == ST_IGNITE && $past(st_q[i]) == ST_HALTED)
				|-> $past(start_go) && $past(dlg_inst_q) == 1'(i))
				else $error("instance started without its own start");

			prove_retry_a: assert property (@(posedge ref_clk) disable iff (reset)
				(st_q[i] == ST_PROVE && sec_tick && tmr_q[i] <= TIME_W'(1) && !flame[i]
				&& !inst_fault[i] && !stop_btn && !glob_q && !glob_fault && !clr_glob_go)
				|=> st_q[i] == ST_IGNITE ##0 ign_drive[i])
				else $error("no retry after failed proving");

			glob_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
				(clr_glob_go && st_q[i] != ST_ALARM && !inst_fault[i] && !glob_fault)
				|=> st_q[i] == ST_HALTED && !glob_q)
				else $error("global clear did not halt instance");
		end
	endgenerate

	// ----------------------------------------------------------------
	// log erase and export
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			erase_q <= 1'b0;
		else
			erase_q <= erase_go;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			datetime_q <= '0;
			site_q     <= '0;
		end
		else if (reg_wr && reg_addr == REG_DATETIME)
			datetime_q <= reg_wdata;
		else if (reg_wr && reg_addr == REG_SITE)
			site_q <= reg_wdata;
	end

	// names are latched so a clock update mid-export cannot tear them
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			valid_q  <= 1'b0;
			folder_q <= '0;
			file_q   <= '0;
		end
		else
		begin
			valid_q <= export_req;
			if (export_req)
			begin
				folder_q <= site_q;
				file_q   <= datetime_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset || !reg_rd)
			rdata_q <= '0;
		else
		begin
			rdata_q <= '0;
			case (reg_addr)
				REG_CFG0:     rdata_q <= cfg_q[0];
				REG_CFG1:     rdata_q <= cfg_q[1];
				REG_THR0:     rdata_q <= thr_q[0];
				REG_THR1:     rdata_q <= thr_q[1];
				REG_DATETIME: rdata_q <= datetime_q;
				REG_SITE:     rdata_q <= site_q;
				REG_STATUS:
				begin
					rdata_q[2:0]                  <= st_q[0];
					rdata_q[STS_ST1_LSB +: 3]     <= st_q[1];
					rdata_q[STS_GLOB]             <= glob_q;
					rdata_q[STS_FLAME0]           <= flame[0];
					rdata_q[STS_FLAME1]           <= flame[1];
					rdata_q[STS_DLG_LSB +: 2]     <= dlg_q;
					rdata_q[STS_REFUSED]          <= refused_q;
				end
				default:      rdata_q <= '0;
			endcase
		end
	end

	assign reg_rdata     = rdata_q;
	assign global_alarm  = glob_q;
	assign log_erase     = erase_q;
	assign export_valid  = valid_q;
	assign export_folder = folder_q;
	assign export_file   = file_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_erase_commit;
		dlg_q == DLG_CHOOSE && dlg_cmd_q == CMD_ERASE && key_ok && yes_sel_q;
	endsequence

	sequence s_one_pulse;
		log_erase ##1 !log_erase;
	endsequence

	erase_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
		s_erase_commit |=> s_one_pulse)
		else $error("erase pulse missing after yes and OK");

	erase_guard_a: assert property (@(posedge ref_clk) disable iff (reset)
		log_erase |-> $past(yes_sel_q) && $past(dlg_cmd_q) == CMD_ERASE && $past(key_ok))
		else $error("logs erased without yes and OK");

	clear_refuse_a: assert property (@(posedge ref_clk) disable iff (reset)
		(commit && dlg_cmd_q == CMD_CLR_INST && inst_fault[dlg_inst_q])
		|=> refused_q && st_q[dlg_inst_q] == ST_ALARM)
		else $error("alarm cleared while cause present");

	factory_def_a: assert property (@(posedge ref_clk) disable iff (reset)
		factory_go |=> cfg_q[0][CFG_EN_BIT] && !cfg_q[1][CFG_EN_BIT]
		&& cfg_q[1][CFG_PRV_LSB +: TIME_W] == DEF_PRV_TIME
		&& thr_q[1][THR_OFF_LSB +: TEMP_W] == DEF_OFF_TEMP)
		else $error("factory defaults not loaded");

	export_name_a: assert property (@(posedge ref_clk) disable iff (reset)
		export_req |=> export_valid && export_file == $past(datetime_q)
		&& export_folder == $past(site_q))
		else $error("export names not taken from clock and site");

endmodule : dps_sequencer

// ---- dps_pilot_model.sv ----
// pilot burner and thermocouple model driven by the igniter outputs
module dps_pilot_model
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [1:0]  ign_drive,
	input  wire logic [1:0]  fuel,
	output logic      [11:0] tc_temp0,
	output logic      [11:0] tc_temp1
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]  lit_q;
	logic [11:0] t_q [2];

	// ----------------------------------------------------------------
	// flame catches only on a fired igniter with fuel, dies without fuel
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (reset || !fuel[i])
				lit_q[i] <= 1'b0;
			else if (ign_drive[i])
				lit_q[i] <= 1'b1;
			// ramp of 50 per cycle so readings pass through the hysteresis band
			if (reset)
				t_q[i] <= 12'h064;
			else if (lit_q[i] && t_q[i] < 12'h190)
				t_q[i] <= t_q[i] + 12'h032;
			else if (!lit_q[i] && t_q[i] > 12'h064)
				t_q[i] <= t_q[i] - 12'h032;
		end
	end
	assign tc_temp0 = t_q[0];
	assign tc_temp1 = t_q[1];
endmodule : dps_pilot_model

// ---- dps_sequencer_bench.sv ----
// self-checking bench for the dual pilot ignition sequencer
module dps_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dps_pkg::*;
	logic        ref_clk, reset, reg_wr, reg_rd, stop_btn, glob_fault, export_req;
	logic        global_alarm, log_erase, export_valid;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, export_folder, export_file;
	logic [11:0] tc_temp0, tc_temp1;
	logic [1:0]  inst_fault, ign_drive, ign_source, fuel;
	int          err_count, total_checks, cyc, erase_n;

	dps_sequencer #(.TICK_CYCLES(4)) dps_sequencer_i (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .stop_btn(stop_btn), .tc_temp0(tc_temp0),
		.tc_temp1(tc_temp1), .inst_fault(inst_fault), .glob_fault(glob_fault),
		.export_req(export_req), .ign_drive(ign_drive), .ign_source(ign_source),
		.global_alarm(global_alarm), .log_erase(log_erase), .export_valid(export_valid),
		.export_folder(export_folder), .export_file(export_file));
	dps_pilot_model dps_pilot_model_i (.ref_clk(ref_clk), .reset(reset), .ign_drive(ign_drive),
		.fuel(fuel), .tc_temp0(tc_temp0), .tc_temp1(tc_temp1));

	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic cmd(input logic [2:0] c, input logic i);
		wr(REG_CMD, {27'h0000000, i, 1'b0, c});
	endtask : cmd
	task automatic sts(input int i, input int w, input logic [31:0] e, input string n);
		logic [31:0] v;
		rd(REG_STATUS, v);
		chk(n, e, 32'(v >> i) & ((32'h1 << w) - 32'h1));
	endtask : sts
	// polls a state field, bounded by max reads
	task automatic wait_st(input int i, input dps_inst_t e, input int max);
		logic [31:0] v;
		for (int k = 0; k < max; k++)
		begin
			rd(REG_STATUS, v);
			if (v[3*i +: 3] === e)
				break;
		end
		chk("state", 32'(e), 32'(v[3*i +: 3]));
	endtask : wait_st
	function automatic logic [31:0] cfg(input logic en, input logic src, input logic [7:0] ig,
		input logic [7:0] pv);
		return {8'h00, pv, ig, 6'h00, src, en};
	endfunction : cfg

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults();
		logic [31:0] v;
		rd(REG_CFG0, v);
		chk("cfg0", cfg(1'b1, 1'b0, 8'h0A, 8'h32), v);
		rd(REG_CFG1, v);
		chk("cfg1", cfg(1'b0, 1'b0, 8'h0A, 8'h32), v);
		rd(REG_THR0, v);
		chk("thr0", 32'h00C8_012C, v);
		rd(REG_THR1, v);
		chk("thr1", 32'h00C8_012C, v);
		rd(4'hF, v);
		chk("unmapped", 32'h0, v);
	endtask : t_defaults
	task automatic t_cycle();
		wr(REG_CFG0, cfg(1'b1, 1'b0, 8'h01, 8'h02));
		cmd(CMD_START, 1'b0);
		wr(REG_KEY, 32'h1);
		wait_st(0, ST_IGNITE, 2);
		chk("ign_drive", 32'h1, 32'(ign_drive));
		wait_st(1, ST_HALTED, 1);
		wait_st(0, ST_PROVE, 20);
		wait_st(0, ST_IGNITE, 30);
		@(posedge ref_clk) fuel <= 2'b01;
		wait_st(0, ST_LIT, 40);
		sts(STS_FLAME0, 1, 32'h1, "flame0");
		cmd(CMD_START, 1'b0);
		sts(STS_REFUSED, 1, 32'h1, "refused");
		wait_st(0, ST_LIT, 1);
	endtask : t_cycle
	task automatic t_stop();
		wr(REG_CFG1, cfg(1'b1, 1'b1, 8'h01, 8'h02));
		cmd(CMD_START, 1'b1);
		wr(REG_KEY, 32'h1);
		wait_st(1, ST_IGNITE, 2);
		chk("ign_source", 32'h2, 32'(ign_source));
		wait_st(0, ST_LIT, 1);
		@(posedge ref_clk) stop_btn <= 1'b1;
		@(posedge ref_clk) stop_btn <= 1'b0;
		wait_st(0, ST_HALTED, 1);
		wait_st(1, ST_HALTED, 1);
		@(posedge ref_clk) fuel <= 2'b00;
	endtask : t_stop
	task automatic t_inst_alarm();
		cmd(CMD_START, 1'b1);
		wr(REG_KEY, 32'h1);
		inst_fault <= 2'b01;
		wait_st(0, ST_ALARM, 3);
		@(posedge ref_clk) stop_btn <= 1'b1;
		@(posedge ref_clk) stop_btn <= 1'b0;
		wait_st(0, ST_ALARM, 1);
		wait_st(1, ST_HALTED, 1);
		cmd(CMD_CLR_INST, 1'b0);
		wr(REG_KEY, 32'h2);
		wr(REG_KEY, 32'h1);
		sts(STS_REFUSED, 1, 32'h1, "refused");
		wait_st(0, ST_ALARM, 1);
		@(posedge ref_clk) inst_fault <= 2'b00;
		cmd(CMD_CLR_INST, 1'b0);
		wr(REG_KEY, 32'h2);
		wr(REG_KEY, 32'h1);
		wait_st(0, ST_HALTED, 2);
		sts(STS_GLOB, 1, 32'h0, "global");
	endtask : t_inst_alarm
	task automatic t_glob();
		cmd(CMD_START, 1'b0);
		wr(REG_KEY, 32'h1);
		glob_fault <= 1'b1;
		wait_st(0, ST_IGNITE, 3);
		chk("global_alarm", 32'h1, 32'(global_alarm));
		chk("ign_drive", 32'h0, 32'(ign_drive));
		@(posedge ref_clk) glob_fault <= 1'b0;
		cmd(CMD_CLR_GLOB, 1'b0);
		wr(REG_KEY, 32'h1);
		wr(REG_KEY, 32'h2);
		wr(REG_KEY, 32'h1);
		wait_st(0, ST_HALTED, 2);
		wait_st(1, ST_HALTED, 1);
		chk("global_alarm", 32'h0, 32'(global_alarm));
	endtask : t_glob
	task automatic t_erase();
		int n;
		n = erase_n;
		cmd(CMD_ERASE, 1'b0);
		wr(REG_KEY, 32'h4);
		cmd(CMD_ERASE, 1'b0);
		wr(REG_KEY, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("erase_no", 32'(n), 32'(erase_n));
		cmd(CMD_ERASE, 1'b0);
		wr(REG_KEY, 32'h2);
		wr(REG_KEY, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("erase_yes", 32'(n + 1), 32'(erase_n));
	endtask : t_erase
	task automatic t_export();
		wr(REG_DATETIME, 32'h2019_0915);
		wr(REG_SITE, 32'h0000_5A17);
		@(posedge ref_clk) export_req <= 1'b1;
		@(posedge ref_clk) export_req <= 1'b0;
		#1;
		chk("export_valid", 32'h1, 32'(export_valid));
		chk("export_folder", 32'h0000_5A17, export_folder);
		chk("export_file", 32'h2019_0915, export_file);
	endtask : t_export
	task automatic t_factory();
		wr(REG_THR1, 32'h0010_0020);
		cmd(CMD_FACTORY, 1'b0);
		t_defaults();
		chk("ign_source", 32'h0, 32'(ign_source));
	endtask : t_factory

	// ----------------------------------------------------------------
	// clock, watchdog, verdict
	// ----------------------------------------------------------------
	task automatic results();
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (log_erase === 1'b1)
			erase_n++;
		if (cyc == 20000)
		begin
			err_count++;
			results();
		end
	end
	initial
	begin
		{reset, reg_wr, reg_rd, stop_btn, glob_fault, export_req} = 6'h20;
		{reg_addr, reg_wdata, inst_fault, fuel} = '0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		t_defaults();
		t_cycle();
		t_stop();
		t_inst_alarm();
		t_glob();
		t_erase();
		t_export();
		t_factory();
		results();
	end
endmodule : dps_sequencer_bench
